//--- bench/mcrs_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcrs_core_tb import mcrs_pkg::*; ;
  // Operand corners for add and subtract, and the mask operations
  localparam logic [15:0] OPA [4] = '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000};
  localparam mcrs_op_t MOPS [4] = '{OP_AND, OP_OR, OP_XOR, OP_NOT};
  // Stimulus towards the core
  logic clk_sys, rstn, wr_en, ctrl_bit_wr, ctrl_bit_val, alu_req, fetch, pc_load, dram_ofs_sel;
  logic host_ctrl_wr, split_status_mode, bd_rd_valid, xchg_in_valid, core_id, chan_id;
  logic shuffle, rv, rv_d;
  logic [4:0] wr_sel, rd_sel;
  logic [15:0] wr_data, pc_load_val, host_ctrl_data, bd_rd_data, xchg_in_data;
  logic [3:0] alu_op;
  logic [2:0] ctrl_bit_idx, alu_a_sel, alu_b_sel, alu_dst_sel;
  logic [5:0] dram_addr_in, dram_addr;
  // Outputs of the core and of the far side
  logic [15:0] rd_data, own_flags, shared_flags, peer_flags, host_control_word, core_status_word;
  logic [15:0] host_irq_status, backdoor_data_buf, inter_core_exchange, next_instr_pointer;
  logic [15:0] alu_condition_word;
  logic [7:0] backdoor_location;
  logic [3:0][13:0] dac_setting;
  logic [11:0] shared_threshold_dacs;
  logic [15:0] exp_q [$]; // Expected read data, oldest first
  int failures = 0;
  int tests_run = 0;
  mcrs_core u_dut (
    .clk_sys, .rstn, .wr_en, .wr_sel, .wr_data, .rd_sel, .rd_data, .ctrl_bit_wr, .ctrl_bit_idx,
    .ctrl_bit_val, .alu_req, .alu_op, .alu_a_sel, .alu_b_sel, .alu_dst_sel, .fetch, .pc_load,
    .pc_load_val, .dram_addr_in, .dram_ofs_sel, .dram_addr, .peer_flags, .own_flags,
    .shared_flags, .host_ctrl_wr, .host_ctrl_data, .split_status_mode, .host_control_word,
    .core_status_word, .host_irq_status, .bd_rd_valid, .bd_rd_data, .backdoor_data_buf,
    .backdoor_location, .xchg_in_valid, .xchg_in_data, .inter_core_exchange, .core_id,
    .chan_id, .dac_setting, .shared_threshold_dacs, .next_instr_pointer, .alu_condition_word
  );
  mcrs_far_model u_far (.clk_sys, .shuffle, .peer_flags, .host_irq_status);
  // Core clock, 40 ns
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] ex);
    tests_run++;
    if (seen !== ex) begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, ex);
    end
  endtask
  // Decoder register write, one cycle
  task automatic wr(input logic [4:0] s, input logic [15:0] d);
    @(negedge clk_sys);
    wr_en = 1'b1;
    wr_sel = s;
    wr_data = d;
    @(negedge clk_sys);
    wr_en = 1'b0;
  endtask
  // Decoder read; the watcher checks the answer one cycle later, on the next falling edge
  task automatic rd(input logic [4:0] s, input logic [15:0] e);
    @(negedge clk_sys);
    rd_sel = s;
    rv = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_sys);
    rv = 0;
  endtask
  // Host write of the command word
  task automatic hostw(input logic [15:0] d);
    @(negedge clk_sys);
    host_ctrl_wr = 1'b1;
    host_ctrl_data = d;
    @(negedge clk_sys);
    host_ctrl_wr = 1'b0;
  endtask
  // ALU request; with busy set a second request is held into the busy window
  task automatic alu(input mcrs_op_t op, input logic [2:0] a, b, d, input logic busy);
    @(negedge clk_sys);
    alu_req = 1'b1;
    alu_op = op;
    alu_a_sel = a;
    alu_b_sel = b;
    alu_dst_sel = d;
    @(negedge clk_sys);
    if (busy) begin
      chk(alu_condition_word, 16'h0000);
      alu_op = OP_ADD;
      alu_dst_sel = 3'h2;
      @(negedge clk_sys);
    end
    alu_req = 1'b0;
    for (int i = 0; i < 8 && alu_condition_word[0] !== 1'b1; i++) begin
      @(negedge clk_sys);
    end
  endtask
  // Expected {condition word, result} of add or subtract
  function automatic logic [31:0] asx(input logic s, input logic [1:0] m, input logic [15:0] a, b);
    logic [16:0] t;
    logic ov;
    logic [15:0] r;
    t = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    ov = (a[15] == (b[15] ^ s)) && (t[15] != a[15]);
    r = t[15:0];
    if (m == SAT_S && ov) r = a[15] ? SMIN : SMAX;
    if (m == SAT_U && t[16]) r = s ? RST16 : UMAX;
    return {2'b00, t[16], m, 4'h0, r == RST16, r[15], s & t[16], !s & t[16],
            ov & a[15], ov & !a[15], 1'b1, r};
  endfunction
  // Expected mask result
  function automatic logic [15:0] mk(input mcrs_op_t op, input logic [15:0] a, m);
    case (op)
      OP_AND: return a & m;
      OP_OR: return a | m;
      OP_XOR: return a ^ m;
      default: return ~a & m;
    endcase
  endfunction
  // Read watcher takes the oldest note when the answer shows
  always @(posedge clk_sys) rv_d <= rv;
  always @(negedge clk_sys) begin
    if (rv_d === 1'b1) begin
      chk(rd_data, exp_q.pop_front());
    end
  end
  // Verdict and end of run
  task automatic print_verdict();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    #400000;
    failures++;
    print_verdict();
  end
  // Main sequence
  initial begin
    logic [15:0] v, w, a;
    logic [31:0] e;
    logic [15:0] gp [8];
    logic cs;
    void'($urandom(32'h3B2DC54D));
    {rstn, wr_en, ctrl_bit_wr, ctrl_bit_val, alu_req, fetch, pc_load, dram_ofs_sel} = '0;
    {host_ctrl_wr, split_status_mode, bd_rd_valid, xchg_in_valid, core_id, chan_id} = '0;
    {shuffle, rv, wr_sel, rd_sel, wr_data, pc_load_val, host_ctrl_data, bd_rd_data} = '0;
    {xchg_in_data, alu_op, ctrl_bit_idx, alu_a_sel, alu_b_sel, alu_dst_sel, dram_addr_in} = '0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    chk(alu_condition_word, COND_RST);
    chk(shared_flags, FLAG_RST);
    // Whole file, immediate and product halves as plain registers
    foreach (gp[i]) begin
      gp[i] = 16'($urandom);
      wr(5'(i), gp[i]);
    end
    foreach (gp[i]) rd(5'(i), gp[i]);
    // Own drive against the three peers
    v = 16'($urandom);
    wr(SEL_FLAG, v);
    shuffle = 1'b1;
    @(negedge clk_sys);
    shuffle = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(own_flags, v);
    chk(shared_flags, v & peer_flags);
    // Command word: core write refused, then status mode
    v = 16'($urandom);
    hostw(v);
    wr(SEL_CTRL, ~v);
    rd(SEL_CTRL, v);
    split_status_mode = 1'b1;
    w = 16'($urandom);
    hostw(w);
    v = {v[15:8], w[7:0]};
    chk(host_control_word, v);
    ctrl_bit_wr = 1'b1;
    ctrl_bit_idx = 3'h3;
    ctrl_bit_val = ~v[11];
    @(negedge clk_sys);
    ctrl_bit_wr = 1'b0;
    v[11] = ~v[11];
    chk(host_control_word, v);
    // Status word, backdoor and exchange, inbound loads included
    wr(SEL_STATUS, w);
    rd(SEL_STATUS, w);
    chk(core_status_word, w);
    wr(SEL_BD_LOC, 16'hFFA5);
    chk({8'h00, backdoor_location}, 16'h00A5);
    bd_rd_valid = 1'b1;
    bd_rd_data = ~w;
    xchg_in_valid = 1'b1;
    xchg_in_data = w;
    @(negedge clk_sys);
    bd_rd_valid = 1'b0;
    xchg_in_valid = 1'b0;
    chk(backdoor_data_buf, ~w);
    rd(SEL_XCHG, w);
    wr(SEL_XCHG, v);
    chk(inter_core_exchange, v);
    wr(SEL_BD_DATA, v);
    rd(SEL_BD_DATA, v);
    // Slot rotation for every core and channel identity
    for (int id = 0; id < 4; id++) begin
      {chan_id, core_id} = 2'(id);
      for (int s = 0; s < 4; s++) begin
        v = 16'($urandom) | 16'hC000;
        wr(SEL_DAC_FIRST + 5'(s), v);
        chk({2'b00, dac_setting[2'(s ^ id)]}, v & 16'h3FFF);
        rd(SEL_DAC_FIRST + 5'(s), v & 16'h3FFF);
      end
    end
    wr(SEL_THR, 16'hFFFF);
    chk({4'h0, shared_threshold_dacs}, 16'h0FFF);
    // Interrupt mirror ignores writes
    shuffle = 1'b1;
    wr(SEL_IRQ, 16'h0000);
    shuffle = 1'b0;
    rd(SEL_IRQ, host_irq_status);
    // Jump load beats fetch, then fetches advance and wrap
    pc_load = 1'b1;
    pc_load_val = 16'hFFFE;
    fetch = 1'b1;
    @(negedge clk_sys);
    pc_load = 1'b0;
    repeat (3) @(negedge clk_sys);
    fetch = 1'b0;
    chk(next_instr_pointer, 16'h0001);
    // Indexed address wraps in 64 words
    wr(SEL_OFS, 16'hFFFF);
    dram_addr_in = 6'h05;
    dram_ofs_sel = 1'b1;
    @(negedge clk_sys);
    chk({10'h000, dram_addr}, 16'h0004);
    // Add and subtract in every mode over boundary operands
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 10; k++) begin
        a = k < 8 ? OPA[k % 4] : 16'($urandom);
        v = k < 8 ? 16'h0001 : 16'($urandom);
        wr(SEL_COND, {3'b000, 2'(m), 11'h000});
        wr(5'h00, a);
        wr(5'h01, v);
        alu(k % 2 ? OP_SUB : OP_ADD, 3'h0, 3'h1, 3'h2, 1'b0);
        e = asx(1'(k), 2'(m), a, v);
        rd(5'h02, e[15:0]);
        rd(SEL_COND, e[31:16]);
      end
    end
    // Mask operations; carry must survive them
    for (int k = 0; k < 12; k++) begin
      a = 16'($urandom);
      w = k < 4 ? 16'h0000 : k < 8 ? 16'hFFFF : 16'($urandom);
      wr(SEL_COND, 16'h2000);
      wr(5'h00, a);
      wr({2'b00, GP_IMM}, w);
      alu(MOPS[k % 4], 3'h0, GP_IMM, 3'h3, 1'b0);
      v = mk(MOPS[k % 4], a, w);
      rd(5'h03, v);
      rd(SEL_COND, {5'h04, v == 16'h0000, v == 16'hFFFF, 9'h001});
    end
    // Multiply with a request refused while busy
    for (int k = 0; k < 2; k++) begin
      a = k ? 16'($urandom) : 16'h0000;
      v = 16'($urandom);
      wr(5'h00, a);
      wr(5'h01, v);
      wr(5'h02, 16'hA5A5);
      wr(SEL_COND, 16'h0000);
      alu(OP_MUL, 3'h0, 3'h1, GP_PHI, 1'b1);
      e = a * v;
      rd({2'b00, GP_PHI}, e[31:16]);
      rd({2'b00, GP_PLO}, e[15:0]);
      rd(5'h02, 16'hA5A5);
      rd(SEL_COND, {7'h00, |e[31:16], |e[15:0], 7'h01});
    end
    // Sign accumulation and its clearing operand
    wr(SEL_COND, 16'h0000);
    cs = 1'b0;
    for (int k = 0; k < 3; k++) begin
      a = k ? 16'h0123 : 16'h8005;
      wr(5'h00, a);
      alu(OP_TOINT, 3'h0, 3'(k / 2), 3'h4, 1'b0);
      cs = (k == 2 ? 1'b0 : cs) ^ a[15];
      rd(5'h04, k ? 16'h0123 : 16'h7FFB);
      rd(SEL_COND, {1'b0, cs, 14'h0001});
    end
    @(negedge clk_sys);
    print_verdict();
  end
endmodule
`default_nettype wire

//--- bench/mcrs_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcrs_far_model (
  input wire logic clk_sys,
  input wire logic shuffle,
  output logic [15:0] peer_flags,
  output logic [15:0] host_irq_status
);
  // Flag drives of the three other cores, released high after power-up
  logic [2:0][15:0] drv = {3{16'hFFFF}};
  // Host view of the interrupt status
  logic [15:0] irq = 16'h0000;
  // New peer drives and host status whenever the bench asks
  always @(posedge clk_sys) begin
    if (shuffle) begin
      for (int i = 0; i < 3; i++) begin
        drv[i] <= 16'($urandom);
      end
      irq <= 16'($urandom);
    end
  end
  // Any core pulling a flag low wins
  assign peer_flags = drv[0] & drv[1] & drv[2];
  assign host_irq_status = irq;
endmodule
`default_nettype wire

//--- core/mcrs_core.sv
`timescale 1ns/1ps
`default_nettype none
module mcrs_core import mcrs_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  // Decoder register access
  input wire logic wr_en,
  input wire logic [4:0] wr_sel,
  input wire logic [15:0] wr_data,
  input wire logic [4:0] rd_sel,
  output logic [15:0] rd_data,
  // Status-mode single bit write of control high byte
  input wire logic ctrl_bit_wr,
  input wire logic [2:0] ctrl_bit_idx,
  input wire logic ctrl_bit_val,
  // ALU request
  input wire logic alu_req,
  input wire logic [3:0] alu_op,
  input wire logic [2:0] alu_a_sel,
  input wire logic [2:0] alu_b_sel,
  input wire logic [2:0] alu_dst_sel,
  // Fetch and jump
  input wire logic fetch,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_val,
  // Data RAM addressing
  input wire logic [5:0] dram_addr_in,
  input wire logic dram_ofs_sel,
  output logic [5:0] dram_addr,
  // Wired-AND flag bus
  input wire logic [15:0] peer_flags,
  output logic [15:0] own_flags,
  output logic [15:0] shared_flags,
  // Host side
  input wire logic host_ctrl_wr,
  input wire logic [15:0] host_ctrl_data,
  input wire logic split_status_mode,
  output logic [15:0] host_control_word,
  output logic [15:0] core_status_word,
  input wire logic [15:0] host_irq_status,
  // Backdoor
  input wire logic bd_rd_valid,
  input wire logic [15:0] bd_rd_data,
  output logic [15:0] backdoor_data_buf,
  output logic [7:0] backdoor_location,
  // Exchange
  input wire logic xchg_in_valid,
  input wire logic [15:0] xchg_in_data,
  output logic [15:0] inter_core_exchange,
  // DAC mapping identity
  input wire logic core_id,
  input wire logic chan_id,
  output logic [3:0][13:0] dac_setting,
  output logic [11:0] shared_threshold_dacs,
  output logic [15:0] next_instr_pointer,
  output logic [15:0] alu_condition_word
);
  // General register file: r0..r4, immediate, product high, low
  logic [15:0] gpr [0:7];
  // Private state
  logic [15:0] core_irq_mirror;
  logic [5:0] dram_index_offset;
  logic [1:0] busy_cnt;
  logic [31:0] mul_hold;
  logic [2:0] mul_dst;

  // Operands and accept
  logic [15:0] opa;
  logic [15:0] opb;
  logic [15:0] imm;
  logic alu_go;
  logic [1:0] sat_mode;
  logic [31:0] product_pair;
  assign opa = gpr[alu_a_sel];
  assign opb = gpr[alu_b_sel];
  assign imm = gpr[GP_IMM];
  assign sat_mode = alu_condition_word[B_A1:B_A0];
  assign product_pair = {gpr[GP_PHI], gpr[GP_PLO]};
  // Requests while done is low are dropped
  assign alu_go = alu_req && alu_condition_word[B_DN];

  // Add and subtract with flags
  logic [16:0] sum17;
  logic [15:0] arith_res;
  logic uh, ul, so, sl;
  always_comb begin
    if (alu_op == OP_SUB) begin
      sum17 = {1'b0, opa} - {1'b0, opb};
      uh = 1'b0;
      ul = sum17[16];
      so = (opa[15] != opb[15]) && (sum17[15] != opa[15]) && !opa[15];
      sl = (opa[15] != opb[15]) && (sum17[15] != opa[15]) && opa[15];
    end else begin
      sum17 = {1'b0, opa} + {1'b0, opb};
      uh = sum17[16];
      ul = 1'b0;
      so = (opa[15] == opb[15]) && (sum17[15] != opa[15]) && !opa[15];
      sl = (opa[15] == opb[15]) && (sum17[15] != opa[15]) && opa[15];
    end
    // Saturate or wrap by mode
    if (sat_mode == SAT_S && so) begin
      arith_res = SMAX;
    end else if (sat_mode == SAT_S && sl) begin
      arith_res = SMIN;
    end else if (sat_mode == SAT_U && uh) begin
      arith_res = UMAX;
    end else if (sat_mode == SAT_U && ul) begin
      arith_res = RST16;
    end else begin
      arith_res = sum17[15:0];
    end
  end

  // Mask operations against the immediate register
  logic [15:0] mask_res;
  always_comb begin
    case (alu_op)
      OP_AND: mask_res = opa & imm;
      OP_OR: mask_res = opa | imm;
      OP_XOR: mask_res = opa ^ imm;
      default: mask_res = ~opa & imm;
    endcase
  end

  // 32-bit shifts of the product pair
  logic [32:0] shl33;
  logic [32:0] shr33;
  assign shl33 = {1'b0, product_pair} << opb[4:0];
  assign shr33 = {product_pair, 1'b0} >> opb[4:0];

  // Operation class decode
  logic is_arith, is_mask, is_shift;
  assign is_arith = alu_op == OP_ADD || alu_op == OP_SUB;
  assign is_mask = alu_op == OP_AND || alu_op == OP_OR
    || alu_op == OP_XOR || alu_op == OP_NOT;
  assign is_shift = alu_op == OP_SHL || alu_op == OP_SHR;

  // Multiply sequencer: holds done low for a fixed count
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_cnt <= 2'h0;
      mul_hold <= 32'h0;
      mul_dst <= 3'h0;
    end else if (alu_go && alu_op == OP_MUL) begin
      busy_cnt <= MUL_CYCLES;
      mul_hold <= opa * opb;
      mul_dst <= alu_dst_sel;
    end else if (busy_cnt != 2'h0) begin
      busy_cnt <= busy_cnt - 2'h1;
    end
  end

  // Register file: decoder writes, ALU results override
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        gpr[i] <= RST16;
      end
    end else begin
      // Plain decoder write
      if (wr_en && wr_sel <= SEL_GP_LAST) begin
        gpr[wr_sel[2:0]] <= wr_data;
      end
      // Single-cycle results
      if (alu_go && is_arith) begin
        gpr[alu_dst_sel] <= arith_res;
      end else if (alu_go && is_mask) begin
        gpr[alu_dst_sel] <= mask_res;
      end else if (alu_go && alu_op == OP_TOINT) begin
        gpr[alu_dst_sel] <= opa[15] ? 16'(-opa) : opa;
      end else if (alu_go && alu_op == OP_SHL) begin
        {gpr[GP_PHI], gpr[GP_PLO]} <= shl33[31:0];
      end else if (alu_go && alu_op == OP_SHR) begin
        {gpr[GP_PHI], gpr[GP_PLO]} <= shr33[32:1];
      end
      // Product lands when the count expires
      if (busy_cnt == 2'h1) begin
        {gpr[GP_PHI], gpr[GP_PLO]} <= mul_hold;
      end
    end
  end

  // Condition word updates by operation class
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      alu_condition_word <= COND_RST;
    end else begin
      // Decoder may write all but the done bit
      if (wr_en && wr_sel == SEL_COND) begin
        alu_condition_word[15:1] <= wr_data[15:1];
      end
      if (alu_go && is_arith) begin
        alu_condition_word[B_C] <= sum17[16];
        alu_condition_word[B_ZR] <= arith_res == RST16;
        alu_condition_word[B_NG] <= arith_res[15];
        alu_condition_word[B_UL] <= ul;
        alu_condition_word[B_UH] <= uh;
        alu_condition_word[B_SL] <= sl;
        alu_condition_word[B_SO] <= so;
      end
      if (alu_go && is_mask) begin
        alu_condition_word[B_MZ] <= mask_res == RST16;
        alu_condition_word[B_MF] <= mask_res == UMAX;
      end
      if (alu_go && is_shift && opb[4:0] != 5'h0) begin
        alu_condition_word[B_SX] <= alu_op == OP_SHL ? shl33[32] : shr33[0];
      end
      if (alu_go && alu_op == OP_SHL) begin
        alu_condition_word[B_PH] <= |shl33[31:16];
        alu_condition_word[B_PL] <= |shl33[15:0];
      end
      if (alu_go && alu_op == OP_SHR) begin
        alu_condition_word[B_PH] <= |shr33[32:17];
        alu_condition_word[B_PL] <= |shr33[16:1];
      end
      if (busy_cnt == 2'h1) begin
        alu_condition_word[B_PH] <= |mul_hold[31:16];
        alu_condition_word[B_PL] <= |mul_hold[15:0];
      end
      // Sign product accumulation, low bit of the B operand select acts as reset
      if (alu_go && alu_op == OP_TOINT) begin
        alu_condition_word[B_CS] <= (alu_b_sel[0] ? 1'b0 : alu_condition_word[B_CS])
          ^ opa[15];
      end
      // Done bit tracks the sequencer
      alu_condition_word[B_DN] <= !(alu_go && alu_op == OP_MUL)
        && busy_cnt <= 2'h1;
    end
  end

  // Flag bus: own drive and wired-AND view
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      own_flags <= FLAG_RST;
      shared_flags <= FLAG_RST;
    end else begin
      if (wr_en && wr_sel == SEL_FLAG) begin
        own_flags <= wr_data;
      end
      shared_flags <= own_flags & peer_flags;
    end
  end

  // Host control word: host low byte, high byte by split mode
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      host_control_word <= RST16;
    end else begin
      if (host_ctrl_wr) begin
        host_control_word[7:0] <= host_ctrl_data[7:0];
      end
      if (host_ctrl_wr && !split_status_mode) begin
        host_control_word[15:8] <= host_ctrl_data[15:8];
      end else if (ctrl_bit_wr && split_status_mode) begin
        host_control_word[{1'b1, ctrl_bit_idx}] <= ctrl_bit_val;
      end
    end
  end

  // Core-owned words and buffers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      core_status_word <= RST16;
      backdoor_data_buf <= RST16;
      backdoor_location <= 8'h00;
      inter_core_exchange <= RST16;
      shared_threshold_dacs <= 12'h000;
      dram_index_offset <= 6'h00;
      core_irq_mirror <= RST16;
    end else begin
      core_irq_mirror <= host_irq_status;
      if (wr_en && wr_sel == SEL_STATUS) begin
        core_status_word <= wr_data;
      end
      // Read data returned by the backdoor takes precedence
      if (bd_rd_valid) begin
        backdoor_data_buf <= bd_rd_data;
      end else if (wr_en && wr_sel == SEL_BD_DATA) begin
        backdoor_data_buf <= wr_data;
      end
      if (wr_en && wr_sel == SEL_BD_LOC) begin
        backdoor_location <= wr_data[7:0];
      end
      // Peer delivery wins over a local write
      if (xchg_in_valid) begin
        inter_core_exchange <= xchg_in_data;
      end else if (wr_en && wr_sel == SEL_XCHG) begin
        inter_core_exchange <= wr_data;
      end
      if (wr_en && wr_sel == SEL_THR) begin
        shared_threshold_dacs <= wr_data[11:0];
      end
      if (wr_en && wr_sel == SEL_OFS) begin
        dram_index_offset <= wr_data[5:0];
      end
    end
  end

  // Slot to physical DAC rotation
  logic [1:0] map_id;
  assign map_id = {chan_id, core_id};
  for (genvar d = 0; d < 4; d++) begin : g_dac
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        dac_setting[d] <= 14'h0000;
      end else if (wr_en && wr_sel >= SEL_DAC_FIRST && wr_sel <= SEL_DAC_LAST
                   && (wr_sel[1:0] ^ map_id) == 2'(d)) begin
        dac_setting[d] <= wr_data[13:0];
      end
    end
  end

  // Program counter and indexed address
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      next_instr_pointer <= RST16;
      dram_addr <= 6'h00;
    end else begin
      if (pc_load) begin
        next_instr_pointer <= pc_load_val;
      end else if (fetch) begin
        next_instr_pointer <= next_instr_pointer + 16'h0001;
      end
      dram_addr <= dram_addr_in + (dram_ofs_sel ? dram_index_offset : 6'h00);
    end
  end

  // Registered read port
  logic [15:0] next_rd;
  always_comb begin
    next_rd = RST16;
    if (rd_sel <= SEL_GP_LAST) begin
      next_rd = gpr[rd_sel[2:0]];
    end else if (rd_sel >= SEL_DAC_FIRST && rd_sel <= SEL_DAC_LAST) begin
      next_rd = {2'h0, dac_setting[rd_sel[1:0] ^ map_id]};
    end else begin
      case (rd_sel)
        SEL_COND: next_rd = alu_condition_word;
        SEL_FLAG: next_rd = shared_flags;
        SEL_STATUS: next_rd = core_status_word;
        SEL_BD_DATA: next_rd = backdoor_data_buf;
        SEL_THR: next_rd = {4'h0, shared_threshold_dacs};
        SEL_BD_LOC: next_rd = {8'h00, backdoor_location};
        SEL_XCHG: next_rd = inter_core_exchange;
        SEL_CTRL: next_rd = host_control_word;
        SEL_IRQ: next_rd = core_irq_mirror;
        SEL_PC: next_rd = next_instr_pointer;
        default: next_rd = RST16;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_data <= RST16;
    end else begin
      rd_data <= next_rd;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_flag_and: assert property (##1 shared_flags == ($past(own_flags) & $past(peer_flags)))
    else $error("shared flags not ANDed");
  a_ctrl_low_core: assert property (!host_ctrl_wr |=> $stable(host_control_word[7:0]))
    else $error("control low byte changed by core");
  a_ctrl_status: assert property (split_status_mode && !ctrl_bit_wr
    |=> $stable(host_control_word[15:8]))
    else $error("status byte changed without bit write");
  a_pc_step: assert property (fetch && !pc_load
    |=> next_instr_pointer == $past(next_instr_pointer) + 16'h0001)
    else $error("program counter did not advance");
  a_mask_zero: assert property (alu_go && alu_op == OP_AND && imm == RST16
    |=> alu_condition_word[B_MZ] && !alu_condition_word[B_MF])
    else $error("mask zero flag wrong");
  a_sat_signed: assert property (alu_go && alu_op == OP_ADD && sat_mode == SAT_S
    && opa == SMAX && opb == 16'h0001 |=> gpr[$past(alu_dst_sel)] == SMAX)
    else $error("signed saturation failed");
  a_wrap_add: assert property (alu_go && alu_op == OP_ADD && sat_mode == 2'h0
    && opa == UMAX && opb == 16'h0001 |=> gpr[$past(alu_dst_sel)] == 16'h0000
    && alu_condition_word[B_UH])
    else $error("wrapping add wrong");
  a_mul_done: assert property (alu_go && alu_op == OP_MUL
    |=> !alu_condition_word[B_DN] [*2] ##1 alu_condition_word[B_DN])
    else $error("done bit timing wrong");
  a_busy_ignore: assert property (alu_req && !alu_condition_word[B_DN]
    && !(wr_en && wr_sel == SEL_COND) && busy_cnt != 2'h1
    |=> $stable(alu_condition_word[15:1]))
    else $error("request accepted while busy");
  a_mask_keep: assert property (alu_go && is_mask && !(wr_en && wr_sel == SEL_COND)
    |=> $stable(alu_condition_word[B_ZR:B_SO]))
    else $error("arith flags disturbed by mask op");
  a_prod_flags: assert property ($rose(alu_condition_word[B_DN])
    |-> alu_condition_word[B_PH] == (gpr[GP_PHI] != RST16))
    else $error("product overflow flag wrong");
  c_mul: cover property (alu_go && alu_op == OP_MUL ##3 alu_condition_word[B_DN]);
  c_sat_u: cover property (alu_go && alu_op == OP_SUB && sat_mode == SAT_U && ul);
  c_mask_ones: cover property (alu_go && is_mask ##1 alu_condition_word[B_MF]);
endmodule
`default_nettype wire

//--- include/mcrs_pkg.sv
// How it works
// - Shared flags are AND of all cores
// - Control low byte: host writes, core reads
// - Control high byte: mirror mode or status mode
// - Status word: core read/write, host read-only
// - Backdoor data buffer and location register
// - DAC slots map to DACs by rotation
// - Slot DAC: offset [13:8], value [7:0]
// - Shared DAC: negative [11:8], high [7:0]
// - Interrupt mirror copies host status continuously
// - Exchange register passes data between cores
// - Program counter increments on each fetch without a jump load; a jump load wins
// - Index offset added when offset selected
// - Immediate register is mask source, also general
// - Product pair holds multiply and shift results
// - Condition word bit layout fixed
// - Shift-out, carry and conversion sign capture
// - Modes 00/10 wrap add and subtract
// - Mode 01 signed, 11 unsigned saturation
// - Mask result sets all-zero/all-ones flags
// - Product halves nonzero set overflow/precision flags
// - Add/subtract update zero, sign, overflow flags
// - Done bit low while busy; requests ignored
package mcrs_pkg;
  // Register select codes for decoder reads and writes
  localparam logic [4:0] SEL_GP_LAST = 5'h07;
  localparam logic [4:0] SEL_COND = 5'h08;
  localparam logic [4:0] SEL_FLAG = 5'h09;
  localparam logic [4:0] SEL_STATUS = 5'h0A;
  localparam logic [4:0] SEL_BD_DATA = 5'h0B;
  localparam logic [4:0] SEL_DAC_FIRST = 5'h0C;
  localparam logic [4:0] SEL_DAC_LAST = 5'h0F;
  localparam logic [4:0] SEL_THR = 5'h10;
  localparam logic [4:0] SEL_BD_LOC = 5'h11;
  localparam logic [4:0] SEL_XCHG = 5'h12;
  localparam logic [4:0] SEL_OFS = 5'h13;
  localparam logic [4:0] SEL_CTRL = 5'h14;
  localparam logic [4:0] SEL_IRQ = 5'h15;
  localparam logic [4:0] SEL_PC = 5'h16;
  // General register indices inside the file
  localparam logic [2:0] GP_IMM = 3'h5;
  localparam logic [2:0] GP_PHI = 3'h6;
  localparam logic [2:0] GP_PLO = 3'h7;
  // Condition word bit positions
  localparam int B_SX = 15;
  localparam int B_CS = 14;
  localparam int B_C = 13;
  localparam int B_A1 = 12;
  localparam int B_A0 = 11;
  localparam int B_MZ = 10;
  localparam int B_MF = 9;
  localparam int B_PH = 8;
  localparam int B_PL = 7;
  localparam int B_ZR = 6;
  localparam int B_NG = 5;
  localparam int B_UL = 4;
  localparam int B_UH = 3;
  localparam int B_SL = 2;
  localparam int B_SO = 1;
  localparam int B_DN = 0;
  // Reset values and timing
  localparam logic [15:0] RST16 = 16'h0000;
  localparam logic [15:0] FLAG_RST = 16'hFFFF;
  localparam logic [15:0] COND_RST = 16'h0001;
  localparam logic [1:0] MUL_CYCLES = 2'h2;
  // Saturation limits
  localparam logic [15:0] SMAX = 16'h7FFF;
  localparam logic [15:0] SMIN = 16'h8000;
  localparam logic [15:0] UMAX = 16'hFFFF;
  // Saturation modes
  localparam logic [1:0] SAT_S = 2'h1;
  localparam logic [1:0] SAT_U = 2'h3;
  // ALU operations
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_OR = 4'h3,
    OP_XOR = 4'h4, OP_NOT = 4'h5, OP_MUL = 4'h6, OP_SHL = 4'h7,
    OP_SHR = 4'h8, OP_TOINT = 4'h9
  } mcrs_op_t;
endpackage
